// file: pcg_clock_branch_ctrl.v
// Our own choice: strobed register access.
`include "pcg_defs.vh"

// How it works
// - pdn bit 2 stops group three-a transmit branches
// - spare bit 30 stops three-a dynamic link branch
// - force bit 25 stops three-a permanent link branch
// - pdn bit 3 stops group three-b transmit branches
// - spare bit 31 stops three-b dynamic link branch
// - force bit 26 stops three-b permanent link branch
// - gated core ignores further register accesses
// - each branch has its own separate control bit
module pcg_clock_branch_ctrl
#(
    parameter ADDR_W = `PCG_ADDR_W,
    parameter DATA_W = `PCG_DATA_W
)
(
    input  wire              i_ref_clk,
    input  wire              i_reset,
    input  wire [ADDR_W-1:0] i_addr,
    input  wire [DATA_W-1:0] i_wdata,
    input  wire              i_wr,
    input  wire              i_rd,
    output wire [DATA_W-1:0] o_rdata,
    output wire              o_tx_branch_run_three_a,
    output wire              o_dyn_link_branch_run_three_a,
    output wire              o_perm_link_branch_run_three_a,
    output wire              o_tx_branch_run_three_b,
    output wire              o_dyn_link_branch_run_three_b,
    output wire              o_perm_link_branch_run_three_b,
    output reg               o_core_access_en_three_a,
    output reg               o_core_access_en_three_b,
    output reg               o_debug_three_a,
    output reg               o_debug_three_b
);

    // ======================================================================
    // register words
    // ======================================================================
    wire [DATA_W-1:0]             pdn_w;     // power-down control
    wire [DATA_W-1:0]             force_w;   // permanent branch force-off
    wire [DATA_W-1:0]             debug_w;   // translation debug word
    wire [DATA_W-1:0]             spare_w;   // top clock spare
    wire [`PCG_NUM_BRANCH-1:0]    stop_w;    // stop request per branch
    wire [`PCG_NUM_BRANCH-1:0]    run_w;     // registered run enables
    wire [`PCG_NUM_BRANCH-1:0]    stopped_w; // branch confirmed stopped
    reg  [DATA_W-1:0]             status_w;  // read-only status word

    pcg_reg_bank
    #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    )
    u_bank
    (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_addr    (i_addr),
        .i_wdata   (i_wdata),
        .i_wr      (i_wr),
        .i_rd      (i_rd),
        .i_status  (status_w),
        .o_pdn     (pdn_w),
        .o_force   (force_w),
        .o_debug   (debug_w),
        .o_spare   (spare_w),
        .o_rdata   (o_rdata)
    );

    // ======================================================================
    // stop requests: every branch from its own bit
    // ======================================================================
    assign stop_w[`PCG_BR_TX_3A]   = pdn_w[`PCG_PDN_TX_3A];
    assign stop_w[`PCG_BR_DYN_3A]  = spare_w[`PCG_SPARE_DYN_3A];
    assign stop_w[`PCG_BR_PERM_3A] = force_w[`PCG_FORCE_PERM_3A];
    assign stop_w[`PCG_BR_TX_3B]   = pdn_w[`PCG_PDN_TX_3B];
    assign stop_w[`PCG_BR_DYN_3B]  = spare_w[`PCG_SPARE_DYN_3B];
    assign stop_w[`PCG_BR_PERM_3B] = force_w[`PCG_FORCE_PERM_3B];

    // independent enable per branch
    pcg_branch_gate
    #(
        .NUM (`PCG_NUM_BRANCH)
    )
    u_gate
    (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_stop    (stop_w),
        .o_run     (run_w),
        .o_stopped (stopped_w)
    );

    assign o_tx_branch_run_three_a        = run_w[`PCG_BR_TX_3A];
    assign o_dyn_link_branch_run_three_a  = run_w[`PCG_BR_DYN_3A];
    assign o_perm_link_branch_run_three_a = run_w[`PCG_BR_PERM_3A];
    assign o_tx_branch_run_three_b        = run_w[`PCG_BR_TX_3B];
    assign o_dyn_link_branch_run_three_b  = run_w[`PCG_BR_DYN_3B];
    assign o_perm_link_branch_run_three_b = run_w[`PCG_BR_PERM_3B];

    // ======================================================================
    // core access enables: any branch of a group asked to stop blocks accesses
    // ======================================================================
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_core_access_en_three_a <= 1'b1;
            o_core_access_en_three_b <= 1'b1;
            o_debug_three_a          <= 1'b0;
            o_debug_three_b          <= 1'b0;
        end
        else
        begin
            // block once the group's clocks are asked to stop
            o_core_access_en_three_a <= ~(stop_w[`PCG_BR_TX_3A]
                                         | stop_w[`PCG_BR_DYN_3A]
                                         | stop_w[`PCG_BR_PERM_3A]);
            o_core_access_en_three_b <= ~(stop_w[`PCG_BR_TX_3B]
                                         | stop_w[`PCG_BR_DYN_3B]
                                         | stop_w[`PCG_BR_PERM_3B]);
            // debug bits passed out to the translation unit
            o_debug_three_a <= debug_w[`PCG_DEBUG_3A];
            o_debug_three_b <= debug_w[`PCG_DEBUG_3B];
        end
    end

    // ======================================================================
    // status word assembly
    // ======================================================================
    always @*
    begin
        status_w                  = `PCG_RST_WORD;
        status_w[`PCG_ST_TX_3A]   = stopped_w[`PCG_BR_TX_3A];
        status_w[`PCG_ST_DYN_3A]  = stopped_w[`PCG_BR_DYN_3A];
        status_w[`PCG_ST_PERM_3A] = stopped_w[`PCG_BR_PERM_3A];
        status_w[`PCG_ST_TX_3B]   = stopped_w[`PCG_BR_TX_3B];
        status_w[`PCG_ST_DYN_3B]  = stopped_w[`PCG_BR_DYN_3B];
        status_w[`PCG_ST_PERM_3B] = stopped_w[`PCG_BR_PERM_3B];
        status_w[`PCG_ST_BLK_3A]  = ~o_core_access_en_three_a;
        status_w[`PCG_ST_BLK_3B]  = ~o_core_access_en_three_b;
    end

endmodule

// file: pcg_defs.vh
`ifndef PCG_DEFS_VH
`define PCG_DEFS_VH

// ==========================================================================
// register indices (word-wide registers, addressed by index)
// ==========================================================================
`define PCG_ADDR_W          8
`define PCG_DATA_W          32
`define PCG_IDX_PDN         8'h07   // core_power_down_control
`define PCG_IDX_FORCE       8'h27   // core_clock_force_off_config
`define PCG_IDX_DEBUG       8'h46   // translation_l2_debug_two
`define PCG_IDX_SPARE       8'he0   // top_clock_spare_a
`define PCG_IDX_STATUS      8'hf0   // branch state, read only

// ==========================================================================
// reset values
// ==========================================================================
`define PCG_RST_WORD        32'h0000_0000
`define PCG_RD_UNMAPPED     32'h0000_0000

// ==========================================================================
// field positions
// ==========================================================================
`define PCG_PDN_TX_3A       2
`define PCG_PDN_TX_3B       3
`define PCG_SPARE_DYN_3A    30
`define PCG_SPARE_DYN_3B    31
`define PCG_FORCE_PERM_3A   25
`define PCG_FORCE_PERM_3B   26
`define PCG_DEBUG_3A        3
`define PCG_DEBUG_3B        4

// status word layout: one bit per stopped branch, then access blocks
`define PCG_ST_TX_3A        0
`define PCG_ST_DYN_3A       1
`define PCG_ST_PERM_3A      2
`define PCG_ST_TX_3B        3
`define PCG_ST_DYN_3B       4
`define PCG_ST_PERM_3B      5
`define PCG_ST_BLK_3A       6
`define PCG_ST_BLK_3B       7
`define PCG_ST_USED_W       8

// branch vector layout inside the gate module
`define PCG_NUM_BRANCH      6
`define PCG_BR_TX_3A        0
`define PCG_BR_DYN_3A       1
`define PCG_BR_PERM_3A      2
`define PCG_BR_TX_3B        3
`define PCG_BR_DYN_3B       4
`define PCG_BR_PERM_3B      5

// one-hot select codes from the address decoder
`define PCG_SEL_W           5
`define PCG_SEL_NONE        5'h00
`define PCG_SEL_PDN         5'h01
`define PCG_SEL_FORCE       5'h02
`define PCG_SEL_DEBUG       5'h04
`define PCG_SEL_SPARE       5'h08
`define PCG_SEL_STATUS      5'h10

`endif

// file: pcg_reg_bank.v
`include "pcg_defs.vh"

// ==========================================================================
// register bank: four read/write words and one read-only status word
// ==========================================================================
module pcg_reg_bank
#(
    parameter ADDR_W = `PCG_ADDR_W,
    parameter DATA_W = `PCG_DATA_W
)
(
    input  wire              i_ref_clk,
    input  wire              i_reset,
    input  wire [ADDR_W-1:0] i_addr,
    input  wire [DATA_W-1:0] i_wdata,
    input  wire              i_wr,
    input  wire              i_rd,
    input  wire [DATA_W-1:0] i_status,
    output reg  [DATA_W-1:0] o_pdn,
    output reg  [DATA_W-1:0] o_force,
    output reg  [DATA_W-1:0] o_debug,
    output reg  [DATA_W-1:0] o_spare,
    output reg  [DATA_W-1:0] o_rdata
);

    // ======================================================================
    // address decode, shared by write and read paths
    // ======================================================================
    function [`PCG_SEL_W-1:0] sel_of;
        input [ADDR_W-1:0] addr;
        begin
            if (addr == `PCG_IDX_PDN)
                sel_of = `PCG_SEL_PDN;
            else if (addr == `PCG_IDX_FORCE)
                sel_of = `PCG_SEL_FORCE;
            else if (addr == `PCG_IDX_DEBUG)
                sel_of = `PCG_SEL_DEBUG;
            else if (addr == `PCG_IDX_SPARE)
                sel_of = `PCG_SEL_SPARE;
            else if (addr == `PCG_IDX_STATUS)
                sel_of = `PCG_SEL_STATUS;
            else
                sel_of = `PCG_SEL_NONE;
        end
    endfunction

    wire [`PCG_SEL_W-1:0] sel = sel_of(i_addr); // current access target

    // ======================================================================
    // write path: full-word stores, status word ignores writes
    // ======================================================================
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_pdn   <= `PCG_RST_WORD;
            o_force <= `PCG_RST_WORD;
            o_debug <= `PCG_RST_WORD;
            o_spare <= `PCG_RST_WORD;
        end
        else if (i_wr)
        begin
            // only the addressed word changes
            if (sel == `PCG_SEL_PDN)
                o_pdn <= i_wdata;
            else if (sel == `PCG_SEL_FORCE)
                o_force <= i_wdata;
            else if (sel == `PCG_SEL_DEBUG)
                o_debug <= i_wdata;
            else if (sel == `PCG_SEL_SPARE)
                o_spare <= i_wdata;
        end
    end

    // ======================================================================
    // read path: data registered, valid the cycle after the strobe
    // ======================================================================
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_rdata <= `PCG_RD_UNMAPPED;
        else if (i_rd)
        begin
            if (sel == `PCG_SEL_PDN)
                o_rdata <= o_pdn;
            else if (sel == `PCG_SEL_FORCE)
                o_rdata <= o_force;
            else if (sel == `PCG_SEL_DEBUG)
                o_rdata <= o_debug;
            else if (sel == `PCG_SEL_SPARE)
                o_rdata <= o_spare;
            else if (sel == `PCG_SEL_STATUS)
                o_rdata <= i_status;
            else
                o_rdata <= `PCG_RD_UNMAPPED; // unmapped reads as zero
        end
    end

endmodule

// file: pcg_branch_gate.v
`include "pcg_defs.vh"

// ==========================================================================
// per-branch run enables for downstream latch-based clock gate cells
// ==========================================================================
module pcg_branch_gate
#(
    parameter NUM = `PCG_NUM_BRANCH
)
(
    input  wire           i_ref_clk,
    input  wire           i_reset,
    input  wire [NUM-1:0] i_stop,
    output reg  [NUM-1:0] o_run,
    output reg  [NUM-1:0] o_stopped
);

    genvar g;

    // ======================================================================
    // one flop per enable so it only moves on a clock edge; the gate cell
    // latches it while its clock is low, so the branch never sees a runt
    // ======================================================================
    generate
        for (g = 0; g < NUM; g = g + 1)
        begin : gen_branch
            always @(posedge i_ref_clk)
            begin
                if (i_reset)
                begin
                    o_run[g]     <= 1'b1;
                    o_stopped[g] <= 1'b0;
                end
                else
                begin
                    o_run[g]     <= ~i_stop[g];
                    o_stopped[g] <= ~o_run[g];    // reported once applied
                end
            end
        end
    endgenerate

endmodule

// file: pcg_clock_branch_ctrl_monitor.sv
`include "pcg_defs.vh"

// ==========================================================================
// port checker: branch run enables against register writes, access blocks against the run enables
// ==========================================================================
module pcg_clock_branch_ctrl_monitor
#(
    parameter ADDR_W = `PCG_ADDR_W,
    parameter DATA_W = `PCG_DATA_W
)
(
    input wire logic              i_ref_clk,
    input wire logic              i_reset,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic              i_wr,
    input wire logic              o_tx_branch_run_three_a,
    input wire logic              o_dyn_link_branch_run_three_a,
    input wire logic              o_perm_link_branch_run_three_a,
    input wire logic              o_tx_branch_run_three_b,
    input wire logic              o_dyn_link_branch_run_three_b,
    input wire logic              o_perm_link_branch_run_three_b,
    input wire logic              o_core_access_en_three_a,
    input wire logic              o_core_access_en_three_b
);
    // run enables gathered in status bit order
    wire [5:0] run = {o_perm_link_branch_run_three_b, o_dyn_link_branch_run_three_b,
                      o_tx_branch_run_three_b, o_perm_link_branch_run_three_a,
                      o_dyn_link_branch_run_three_a, o_tx_branch_run_three_a};

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);

    // write to one index, two quiet cycles, then enable is inverse of the bit
    property p_follow(logic [ADDR_W-1:0] idx, int pos, logic en);
        (i_wr && i_addr == idx) ##1 !(i_wr && i_addr == idx) [*2]
            |=> (en != $past(i_wdata[pos], 3));
    endproperty

    tx_gate_3a_a: assert property (p_follow(`PCG_IDX_PDN, `PCG_PDN_TX_3A, run[0]))
        else $error("3a transmit enable wrong");
    dyn_gate_3a_a: assert property (p_follow(`PCG_IDX_SPARE, `PCG_SPARE_DYN_3A, run[1]))
        else $error("3a dynamic link enable wrong");
    perm_gate_3a_a: assert property (p_follow(`PCG_IDX_FORCE, `PCG_FORCE_PERM_3A, run[2]))
        else $error("3a permanent link enable wrong");
    tx_gate_3b_a: assert property (p_follow(`PCG_IDX_PDN, `PCG_PDN_TX_3B, run[3]))
        else $error("3b transmit enable wrong");
    dyn_gate_3b_a: assert property (p_follow(`PCG_IDX_SPARE, `PCG_SPARE_DYN_3B, run[4]))
        else $error("3b dynamic link enable wrong");
    perm_gate_3b_a: assert property (p_follow(`PCG_IDX_FORCE, `PCG_FORCE_PERM_3B, run[5]))
        else $error("3b permanent link enable wrong");
    access_block_3a_a: assert property (o_core_access_en_three_a == &run[2:0])
        else $error("3a access enable disagrees with branches");
    access_block_3b_a: assert property (o_core_access_en_three_b == &run[5:3])
        else $error("3b access enable disagrees with branches");

    // main scenarios reached
    cover property (!run[0] ##1 run[0]);
    cover property (run == 6'h00);
    cover property (!o_core_access_en_three_b && o_core_access_en_three_a);
endmodule

bind pcg_clock_branch_ctrl pcg_clock_branch_ctrl_monitor
    #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon
(
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .o_tx_branch_run_three_a(o_tx_branch_run_three_a),
    .o_dyn_link_branch_run_three_a(o_dyn_link_branch_run_three_a),
    .o_perm_link_branch_run_three_a(o_perm_link_branch_run_three_a),
    .o_tx_branch_run_three_b(o_tx_branch_run_three_b),
    .o_dyn_link_branch_run_three_b(o_dyn_link_branch_run_three_b),
    .o_perm_link_branch_run_three_b(o_perm_link_branch_run_three_b),
    .o_core_access_en_three_a(o_core_access_en_three_a),
    .o_core_access_en_three_b(o_core_access_en_three_b)
);

// file: pcg_clock_branch_ctrl_bench.sv
`include "pcg_defs.vh"

module pcg_clock_branch_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ======================================================================
    // stimulus, observed outputs and counters
    // ======================================================================
    logic        i_ref_clk  = 1'b0;
    logic        i_reset    = 1'b1;
    logic [7:0]  i_addr     = 8'h00;
    logic [31:0] i_wdata    = 32'h0000_0000;
    logic        i_wr       = 1'b0;
    logic        i_rd       = 1'b0;
    wire  [31:0] o_rdata;
    wire  [5:0]  run;           // run enables, status bit order
    wire  [1:0]  acc;           // access enables, 3b then 3a
    wire  [1:0]  dbg;           // debug copies, 3b then 3a
    int          fail_count = 0;
    int          n_checks   = 0;

    // 100 ns clock
    always #50 i_ref_clk = ~i_ref_clk;

    pcg_clock_branch_ctrl dut
    (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_tx_branch_run_three_a(run[0]), .o_dyn_link_branch_run_three_a(run[1]),
        .o_perm_link_branch_run_three_a(run[2]), .o_tx_branch_run_three_b(run[3]),
        .o_dyn_link_branch_run_three_b(run[4]), .o_perm_link_branch_run_three_b(run[5]),
        .o_core_access_en_three_a(acc[0]), .o_core_access_en_three_b(acc[1]),
        .o_debug_three_a(dbg[0]), .o_debug_three_b(dbg[1])
    );

    // ======================================================================
    // bus tasks and comparison
    // ======================================================================
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, exp);
    endtask

    // bounded wait for the branch enables, then judge run, access and debug outputs
    task automatic settle(input logic [5:0] er, input logic [1:0] ed);
        int k;
        // always let one edge pass: access and debug copies lag the write
        for (k = 0; k < 8 && (k == 0 || run !== er); k++)
        begin
            @(posedge i_ref_clk);
            #1;
        end
        check({22'h0, dbg, acc, run}, {22'h0, ed, &er[5:3], &er[2:0], er});
        // bound used up: the compare above has counted it, go to the verdict
        if (run !== er)
            results();
    endtask

    // ======================================================================
    // scenarios
    // ======================================================================
    // every branch running and every word clear out of reset
    task automatic t_reset;
        logic [7:0] ix [6] = '{`PCG_IDX_PDN, `PCG_IDX_FORCE, `PCG_IDX_DEBUG,
                               `PCG_IDX_SPARE, `PCG_IDX_STATUS, 8'h55};
        settle(6'h3f, 2'b00);
        foreach (ix[i])
            rd(ix[i], `PCG_RST_WORD);
    endtask

    // each control bit alone stops only its own branch
    task automatic t_single;
        logic [7:0] ix [6] = '{`PCG_IDX_PDN, `PCG_IDX_SPARE, `PCG_IDX_FORCE,
                               `PCG_IDX_PDN, `PCG_IDX_SPARE, `PCG_IDX_FORCE};
        int bt [6] = '{`PCG_PDN_TX_3A, `PCG_SPARE_DYN_3A, `PCG_FORCE_PERM_3A,
                       `PCG_PDN_TX_3B, `PCG_SPARE_DYN_3B, `PCG_FORCE_PERM_3B};
        for (int i = 0; i < 6; i++)
        begin
            wr(ix[i], 32'h1 << bt[i]);
            settle(~(6'h01 << i), 2'b00);
            rd(`PCG_IDX_STATUS, {24'h0, (i < 3) ? 2'b01 : 2'b10, 6'h01 << i});
            rd(ix[i], 32'h1 << bt[i]);
            wr(ix[i], 32'h0);
            settle(6'h3f, 2'b00);
        end
    endtask

    // debug bits mirror out but leave clocks and access alone
    task automatic t_debug;
        wr(`PCG_IDX_DEBUG, 32'h0000_0018);
        settle(6'h3f, 2'b11);
        wr(`PCG_IDX_DEBUG, 32'h0000_0000);
        settle(6'h3f, 2'b00);
    endtask

    // full gating held, read-only and unmapped writes, then a mid-run reset
    // nothing is attached behind either group here, so software may gate both
    task automatic t_all;
        wr(`PCG_IDX_PDN, 32'hffff_ffff);
        wr(`PCG_IDX_SPARE, 32'hffff_ffff);
        wr(`PCG_IDX_FORCE, 32'hffff_ffff);
        wr(`PCG_IDX_DEBUG, 32'hffff_ffff);
        settle(6'h00, 2'b11);
        repeat (20) @(posedge i_ref_clk);
        settle(6'h00, 2'b11);
        wr(`PCG_IDX_STATUS, 32'h0000_0000);
        wr(8'h55, 32'hffff_ffff);
        rd(`PCG_IDX_STATUS, 32'h0000_00ff);
        rd(8'h55, `PCG_RD_UNMAPPED);
        rd(`PCG_IDX_SPARE, 32'hffff_ffff);
        @(posedge i_ref_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        settle(6'h3f, 2'b00);
        rd(`PCG_IDX_PDN, `PCG_RST_WORD);
    endtask

    // ======================================================================
    // verdict and main sequence
    // ======================================================================
    task automatic results;
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        t_reset;
        t_single;
        t_debug;
        t_all;
        results();
    end
endmodule
